// file: logic/timer_pwm_carrier_gen.sv
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "tpc_map.svh"

module timer_pwm_carrier_gen #(
	parameter bit          CARRIER_CAPABLE = 1'b1,
	parameter logic [11:0] RING_DIV_MASK   = 12'h07F
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// avalon-mm slave
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// companion counter
	input  wire logic        companion_counter_irq,
	// timer outputs
	output logic             timer_output_pin,
	output logic             carrier_output_pin,
	output logic             timer_match_irq,
	output logic             resynced_transfer_strobe
);

	if (RING_DIV_MASK == 12'h000) begin : g_bad_div
		$error("RING_DIV_MASK must divide by more than one");
	end

	tpc_pkg::tpc_state_t cur;
	tpc_pkg::tpc_state_t next;
	logic                tick;
	logic                irq_level;
	logic [7:0]          cmp;
	logic                hit;
	logic                xfer_ok;
	logic                acc;
	logic                wr;
	logic [31:0]         rmux;
	logic                carrier_mode;

	tpc_prescaler #(
		.RING_DIV_MASK (RING_DIV_MASK)
	) u_presc (
		.clk                (clk),
		.reset_n            (reset_n),
		.count_clock_select (cur.cks),
		.tick               (tick)
	);

	// companion interrupt may come from another clock
	tpc_sync3 u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (companion_counter_irq),
		.level    (irq_level)
	);

	always_comb begin
		carrier_mode = CARRIER_CAPABLE && (cur.mode == tpc_pkg::MD_CARRIER);
		cmp          = cur.sel ? cur.duty : cur.cyc;
		hit          = (cur.cnt == cmp);
		xfer_ok      = cur.pend && (cur.age == `TPC_DUTY_XFER_TICKS);
		acc          = (read || write) && !cur.ack;
		wr           = write && cur.ack && byteenable[0];
		case (address[4:2])
			`TPC_OFF_MODE: begin
				rmux = {24'h000000, cur.en, cur.cks, cur.mode,
					cur.lev, cur.oen};
			end
			`TPC_OFF_CYCLE:   rmux = {24'h000000, cur.cyc};
			`TPC_OFF_DUTY:    rmux = {24'h000000, cur.duty_lat};
			`TPC_OFF_CARRIER: begin
				rmux = {29'h00000000, cur.rmc, cur.nrzb, cur.nrz};
			end
			`TPC_OFF_STATUS: begin
				rmux = {21'h000000, cur.pend, cur.sel, cur.wave,
					cur.cnt};
			end
			default:          rmux = 32'h0000_0000;
		endcase

		next     = cur;
		next.irq = 1'b0;
		next.ack = acc;
		if (acc && read) begin
			next.rdata = rmux;
		end

		// pending duty value ages in count clocks
		if (cur.pend && tick && (cur.age != `TPC_DUTY_XFER_TICKS)) begin
			next.age = cur.age + 2'h1;
		end

		case (cur.st)
			tpc_pkg::ST_IDLE: begin
				next.cnt  = 8'h00;
				next.sel  = 1'b0;
				next.wave = 1'b0;
				if (cur.en) begin
					next.st = tpc_pkg::ST_SWALLOW;
				end
			end
			tpc_pkg::ST_SWALLOW: begin
				if (!cur.en) begin
					next.st = tpc_pkg::ST_IDLE;
				end else if (tick) begin
					// first count clock is masked off
					next.st = tpc_pkg::ST_RUN;
				end
			end
			tpc_pkg::ST_RUN: begin
				if (!cur.en) begin
					next.st   = tpc_pkg::ST_IDLE;
					next.cnt  = 8'h00;
					next.sel  = 1'b0;
					next.wave = 1'b0;
					next.pend = 1'b0;
				end else if (tick && hit) begin
					if (carrier_mode) begin
						next.cnt  = 8'h00;
						next.irq  = 1'b1;
						next.wave = !cur.wave;
						next.sel  = !cur.sel;
						if (cur.sel && xfer_ok) begin
							next.duty = cur.duty_lat;
							next.pend = 1'b0;
						end
					end else if (cur.mode == tpc_pkg::MD_PWM) begin
						if (!cur.sel) begin
							next.cnt  = 8'h00;
							next.irq  = 1'b1;
							next.wave = 1'b1;
							next.sel  = 1'b1;
						end else begin
							// counter keeps going so period stays N+1
							next.cnt  = cur.cnt + 8'h01;
							next.wave = 1'b0;
							next.sel  = 1'b0;
							if (xfer_ok) begin
								next.duty = cur.duty_lat;
								next.pend = 1'b0;
							end
						end
					end else begin
						// interval mode: square wave on cycle match
						next.cnt  = 8'h00;
						next.irq  = 1'b1;
						next.wave = !cur.wave;
					end
				end else if (tick) begin
					next.cnt = cur.cnt + 8'h01;
				end
			end
			default: begin
				next.st = tpc_pkg::ST_IDLE;
			end
		endcase

		// master/slave carrier enable transfer
		if (tick) begin
			next.strobe = irq_level;
			if (irq_level && !cur.strobe) begin
				next.xcnt = `TPC_ENA_XFER_TICKS;
			end else if (cur.xcnt != 2'h0) begin
				next.xcnt = cur.xcnt - 2'h1;
				if (cur.xcnt == 2'h1) begin
					next.nrz = cur.nrzb;
				end
			end
		end

		// a high pulse starts only when enabled; gated ends whole, but carrier_output_pin drops as soon as nrz clears
		if (!next.wave) begin
			next.gated = 1'b0;
		end else if (!cur.wave) begin
			next.gated = cur.nrz;
		end

		if (wr) begin
			case (address[4:2])
				`TPC_OFF_MODE: begin
					// other fields frozen while counting
					if (!cur.en) begin
						next.cks  = writedata[`TPC_MODE_CKS_HI:`TPC_MODE_CKS_LO];
						next.mode = writedata[`TPC_MODE_MD_HI:`TPC_MODE_MD_LO];
						next.lev  = writedata[`TPC_MODE_LEV];
						next.oen  = writedata[`TPC_MODE_OEN];
					end
					next.en = writedata[`TPC_MODE_EN];
				end
				`TPC_OFF_CYCLE: begin
					next.cyc = writedata[7:0];
				end
				`TPC_OFF_DUTY: begin
					next.duty_lat = writedata[7:0];
					next.age      = 2'h0;
					if (cur.st == tpc_pkg::ST_IDLE) begin
						next.duty = writedata[7:0];
						next.pend = 1'b0;
					end else begin
						next.pend = 1'b1;
					end
				end
				`TPC_OFF_CARRIER: begin
					next.rmc  = writedata[`TPC_CAR_RMC];
					next.nrzb = writedata[`TPC_CAR_NRZB];
				end
				default: begin
				end
			endcase
		end

		case ({cur.rmc, cur.nrz})
			2'b01:   next.cpin = 1'b1;
			2'b11:   next.cpin = next.gated;
			default: next.cpin = 1'b0;
		endcase
		if (!cur.oen) begin
			next.tpin = 1'b0;
		end else if (carrier_mode) begin
			next.tpin = next.cpin;
		end else begin
			next.tpin = next.wave ^ cur.lev;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next;
		end
	end

	assign readdata                 = cur.rdata;
	assign waitrequest              = (read || write) && !cur.ack;
	assign timer_output_pin         = cur.tpin;
	assign carrier_output_pin       = cur.cpin;
	assign timer_match_irq          = cur.irq;
	assign resynced_transfer_strobe = cur.strobe;

endmodule : timer_pwm_carrier_gen

`default_nettype wire

// file: include/tpc_map.svh
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// register word offsets, decoded from address bits 4:2
`define TPC_OFF_MODE    3'h0
`define TPC_OFF_CYCLE   3'h1
`define TPC_OFF_DUTY    3'h2
`define TPC_OFF_CARRIER 3'h3
`define TPC_OFF_STATUS  3'h4

// timer_mode_reg fields
`define TPC_MODE_EN     7
`define TPC_MODE_CKS_HI 6
`define TPC_MODE_CKS_LO 4
`define TPC_MODE_MD_HI  3
`define TPC_MODE_MD_LO  2
`define TPC_MODE_LEV    1
`define TPC_MODE_OEN    0

// carrier_control_reg fields
`define TPC_CAR_RMC     2
`define TPC_CAR_NRZB    1
`define TPC_CAR_NRZ     0

// reset values
`define TPC_RST_BYTE    8'h00
`define TPC_RST_WORD    32'h0000_0000

// timing counts, in count clocks
`define TPC_DUTY_XFER_TICKS 2'h3
`define TPC_ENA_XFER_TICKS  2'h2

// prescaler masks: divide by mask+1
`define TPC_DIV_MASK_0  12'h000
`define TPC_DIV_MASK_1  12'h003
`define TPC_DIV_MASK_2  12'h00F
`define TPC_DIV_MASK_3  12'h03F
`define TPC_DIV_MASK_4  12'hFFF

`endif

// file: include/tpc_pkg.sv
package tpc_pkg;

	typedef enum logic [1:0] {
		MD_INTERVAL = 2'h0,
		MD_CARRIER  = 2'h1,
		MD_PWM      = 2'h2
	} mode_t;

	// gray along idle -> swallow -> run
	typedef enum logic [1:0] {
		ST_IDLE    = 2'h0,
		ST_SWALLOW = 2'h1,
		ST_RUN     = 2'h3
	} run_state_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic        tick;
	} presc_state_t;

	typedef struct packed {
		logic [2:0] q;
		logic       level;
	} sync_state_t;

	typedef struct packed {
		run_state_t  st;
		logic        en;
		logic [2:0]  cks;
		logic [1:0]  mode;
		logic        lev;
		logic        oen;
		logic [7:0]  cyc;
		logic [7:0]  duty;
		logic [7:0]  duty_lat;
		logic        pend;
		logic [1:0]  age;
		logic        sel;
		logic [7:0]  cnt;
		logic        wave;
		logic        irq;
		logic        rmc;
		logic        nrzb;
		logic        nrz;
		logic        strobe;
		logic [1:0]  xcnt;
		logic        gated;
		logic        tpin;
		logic        cpin;
		logic        ack;
		logic [31:0] rdata;
	} tpc_state_t;

endpackage : tpc_pkg

// file: logic/tpc_sync3.sv
`timescale 1ns/1ns
`default_nettype none

module tpc_sync3 (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// async level in, filtered level out
	input  wire logic async_in,
	output logic      level
);

	tpc_pkg::sync_state_t cur;
	tpc_pkg::sync_state_t next;

	// a change counts only once stages two and three agree
	always_comb begin
		next       = cur;
		next.q     = {cur.q[1:0], async_in};
		if (cur.q[1] == cur.q[2]) begin
			next.level = cur.q[2];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next;
		end
	end

	assign level = cur.level;

endmodule : tpc_sync3

`default_nettype wire

// file: logic/tpc_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpc_map.svh"

module tpc_prescaler #(
	parameter logic [11:0] RING_DIV_MASK = 12'h07F
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// selection and count clock strobe
	input  wire logic [2:0] count_clock_select,
	output logic            tick
);

	tpc_pkg::presc_state_t cur;
	tpc_pkg::presc_state_t next;
	logic [11:0]           mask;
	logic                  legal;

	always_comb begin
		legal = 1'b1;
		case (count_clock_select)
			3'h0:    mask = `TPC_DIV_MASK_0;
			3'h1:    mask = `TPC_DIV_MASK_1;
			3'h2:    mask = `TPC_DIV_MASK_2;
			3'h3:    mask = `TPC_DIV_MASK_3;
			3'h4:    mask = `TPC_DIV_MASK_4;
			3'h5:    mask = RING_DIV_MASK;
			default: begin
				mask  = `TPC_DIV_MASK_0;
				legal = 1'b0;
			end
		endcase
		next      = cur;
		next.cnt  = cur.cnt + 12'h001;
		// prohibited selections simply never tick
		next.tick = legal && ((cur.cnt & mask) == mask);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next;
		end
	end

	assign tick = cur.tick;

endmodule : tpc_prescaler

`default_nettype wire

// file: dv/companion_counter_model.sv
`timescale 1ns/1ns
`default_nettype none

module companion_counter_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// trigger and answer delay in clocks
	input  wire logic       fire,
	input  wire logic [3:0] lag,
	// interrupt towards the timer
	output logic            companion_counter_irq
);
	logic [4:0] cnt;

	// held 8 clocks: the timer count clock must see it several times
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 5'h00;
			companion_counter_irq <= 1'b0;
		end else begin
			if (fire)
				cnt <= 5'h01;
			else if (cnt != 5'h00)
				cnt <= cnt + 5'h01;
			companion_counter_irq <= cnt > {1'b0, lag}
				&& cnt <= {1'b0, lag} + 5'h08;
		end
	end
endmodule : companion_counter_model

`default_nettype wire

// file: dv/timer_pwm_carrier_gen_properties.sv
`timescale 1ns/1ns
`default_nettype none

module timer_pwm_carrier_gen_properties (
	// watched ports
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [4:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        companion_counter_irq,
	input wire logic        timer_output_pin,
	input wire logic        carrier_output_pin,
	input wire logic        timer_match_irq,
	input wire logic        resynced_transfer_strobe
);
	logic [1:0] car;
	wire        wr_ok = write && !waitrequest && byteenable[0];
	wire        wr0   = wr_ok && address[4:2] == 3'h0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			car <= 2'h0;
		else if (wr_ok && address[4:2] == 3'h3)
			car <= writedata[2:1];
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_low2;
		!carrier_output_pin [*2];
	endsequence

	a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer after one wait state");
	a_unmapped_zero: assert property (read && !waitrequest
		&& address[4:2] > 3'h4 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_swallow_first: assert property (
		wr0 && writedata[7] && !writedata[1]
		|=> (!timer_match_irq && !timer_output_pin) [*2])
		else $error("activity right after enable");
	a_irq_pulse: assert property (timer_match_irq |=> !timer_match_irq)
		else $error("interrupt longer than one cycle");
	a_rise_irq: assert property (
		$rose(timer_output_pin) |-> ##[0:1] timer_match_irq)
		else $error("output active without interrupt");
	a_fall_no_irq: assert property (
		$fell(timer_output_pin) |-> !timer_match_irq)
		else $error("interrupt at duty match");
	a_disable_quiet: assert property (
		wr0 && !writedata[7] |-> ##2 !timer_match_irq [*8])
		else $error("interrupt after disable");
	a_strobe_sync: assert property (
		companion_counter_irq [*6] |-> resynced_transfer_strobe)
		else $error("strobe missing");
	a_copy_second: assert property (
		$rose(resynced_transfer_strobe) && car == 2'h1
		|-> s_low2 ##[1:2] carrier_output_pin)
		else $error("enable copy at wrong tick");
endmodule : timer_pwm_carrier_gen_properties

bind timer_pwm_carrier_gen timer_pwm_carrier_gen_properties
	timer_pwm_carrier_gen_properties_inst (
	.clk(clk), .reset_n(reset_n), .address(address), .read(read),
	.write(write), .byteenable(byteenable), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest),
	.companion_counter_irq(companion_counter_irq),
	.timer_output_pin(timer_output_pin),
	.carrier_output_pin(carrier_output_pin),
	.timer_match_irq(timer_match_irq),
	.resynced_transfer_strobe(resynced_transfer_strobe));

`default_nettype wire

// file: dv/timer_pwm_carrier_gen_bench.sv
`timescale 1ns/1ns
`default_nettype none

module timer_pwm_carrier_gen_bench;
	logic        clk, reset_n, read, write, fire;
	logic [4:0]  address;
	logic [3:0]  byteenable, lag;
	logic [31:0] writedata, readdata, rd_val;
	logic        waitrequest, cirq, tpin, cpin, irq, strobe;
	int          fail_count, compares, per, hi;

	timer_pwm_carrier_gen timer_pwm_carrier_gen_inst (
		.clk(clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.companion_counter_irq(cirq), .timer_output_pin(tpin),
		.carrier_output_pin(cpin), .timer_match_irq(irq),
		.resynced_transfer_strobe(strobe));
	companion_counter_model companion_counter_model_inst (
		.clk(clk), .reset_n(reset_n), .fire(fire), .lag(lag),
		.companion_counter_irq(cirq));

	always #50 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// entered just after a rising edge; leaves one idle edge behind
	task automatic bus(input logic rw, input logic [4:0] a,
		input logic [7:0] d, input logic [3:0] be);
		int k;
		k = 0;
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		read <= !rw;
		write <= rw;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		rd_val = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus

	// one interrupt-to-interrupt window of the timer pin
	task automatic measure;
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		per = 0;
		hi = 0;
		do begin
			@(negedge clk);
			per++;
			hi += int'(tpin === 1'b1);
		end while (irq !== 1'b1 && per < 600);
		@(posedge clk);
	endtask : measure

	// every whole run of the carrier pin against its expected width
	task automatic runs(input int n, input int eh, input int el);
		int k, r;
		logic p;
		k = 0;
		while (cpin !== 1'b0 && k < 100) begin
			@(negedge clk);
			k++;
		end
		while (cpin !== 1'b1 && k < 200) begin
			@(negedge clk);
			k++;
		end
		r = 1;
		p = 1'b1;
		repeat (n) begin
			@(negedge clk);
			if (cpin !== p) begin
				chk(r, p ? eh : el);
				r = 0;
				p = cpin;
			end
			r++;
		end
		@(posedge clk);
	endtask : runs

	task automatic pulse(input logic [3:0] l);
		int k;
		k = 0;
		lag <= l;
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		while (strobe !== 1'b1 && k < 60) begin
			@(posedge clk);
			k++;
		end
		repeat (4) @(posedge clk);
	endtask : pulse

	task automatic t_regs;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00, 4'hF);
			chk(rd_val, 32'h0);
		end
		bus(1'b1, 5'h04, 8'h5A, 4'hE);
		bus(1'b0, 5'h04, 8'h00, 4'hF);
		chk(rd_val, 32'h0);
		bus(1'b1, 5'h14, 8'hFF, 4'hF);
		bus(1'b0, 5'h14, 8'h00, 4'hF);
		chk(rd_val, 32'h0);
		bus(1'b1, 5'h0C, 8'h01, 4'hF);
		bus(1'b0, 5'h0C, 8'h00, 4'hF);
		chk(rd_val, 32'h0);
	endtask : t_regs

	task automatic t_pwm;
		bus(1'b1, 5'h04, 8'h04, 4'hF);
		bus(1'b1, 5'h08, 8'h01, 4'hF);
		bus(1'b1, 5'h00, 8'h89, 4'hF);
		measure;
		chk(per, 5);
		chk(hi, 2);
		bus(1'b1, 5'h08, 8'h03, 4'hF);
		measure;
		chk(hi, 2);
		measure;
		chk(hi, 4);
		chk(per, 5);
		bus(1'b0, 5'h08, 8'h00, 4'hF);
		chk(rd_val, 32'h3);
		bus(1'b1, 5'h00, 8'h09, 4'hF);
		repeat (4) @(posedge clk);
		chk({irq, tpin}, 2'b00);
		bus(1'b0, 5'h10, 8'h00, 4'hF);
		chk(rd_val[8:0], 9'h000);
	endtask : t_pwm

	task automatic t_oen;
		bus(1'b1, 5'h08, 8'h01, 4'hF);
		bus(1'b1, 5'h00, 8'h88, 4'hF);
		measure;
		chk(per, 5);
		chk(hi, 0);
		bus(1'b1, 5'h00, 8'h08, 4'hF);
	endtask : t_oen

	task automatic t_carrier;
		bus(1'b1, 5'h04, 8'h03, 4'hF);
		bus(1'b1, 5'h08, 8'h01, 4'hF);
		bus(1'b1, 5'h0C, 8'h02, 4'hF);
		bus(1'b1, 5'h00, 8'h84, 4'hF);
		pulse(4'h0);
		chk(cpin, 1'b1);
		bus(1'b0, 5'h0C, 8'h00, 4'hF);
		chk(rd_val, 32'h3);
		bus(1'b1, 5'h0C, 8'h06, 4'hF);
		runs(60, 2, 4);
		bus(1'b1, 5'h0C, 8'h04, 4'hF);
		pulse(4'h9);
		// active bit is off now: pin must stay low, no new pulse
		repeat (40) begin
			@(negedge clk);
			chk(cpin, 1'b0);
		end
		@(posedge clk);
		chk(cpin, 1'b0);
		bus(1'b0, 5'h0C, 8'h00, 4'hF);
		chk(rd_val, 32'h4);
		bus(1'b1, 5'h00, 8'h04, 4'hF);
	endtask : t_carrier

	task automatic close_out;
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		fire = 1'b0;
		lag = 4'h0;
		address = 5'h00;
		byteenable = 4'h0;
		writedata = 32'h0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_pwm;
		t_oen;
		t_carrier;
		close_out;
	end

	// whole run needs well under 2000 clocks
	initial begin
		repeat (8000) @(posedge clk);
		fail_count++;
		close_out;
	end
endmodule : timer_pwm_carrier_gen_bench

`default_nettype wire
